// ---- hdl/csseq_deglitch.v ----
// level filter: output follows input only after it holds steady
module csseq_deglitch
#(
   parameter LEN = 10
)
(
   // clock and reset
   input wire pclk,
   input wire presetn,
   // level
   input wire din,
   output reg dout
);

reg [7:0] run;

always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      run <= 8'h00;
      dout <= 1'b0;
   end
   else if (din == dout)
   begin
      run <= 8'h00;
   end
   else if (run >= LEN[7:0] - 8'h01)
   begin
      run <= 8'h00;
      dout <= din;
   end
   else
   begin
      run <= run + 8'h01;
   end
end

endmodule // csseq_deglitch

// ---- hdl/csseq_map.vh ----
// constants for the converter start-up sequencer
`ifndef CSSEQ_MAP_VH
`define CSSEQ_MAP_VH

// ----------------------------------------
// clock and times
// ----------------------------------------
`define CSSEQ_CLK_NS 20
`define CSSEQ_CLK_MHZ 50
`define CSSEQ_INIT_US 300
`define CSSEQ_POD_US 500
`define CSSEQ_PG_US 1000
`define CSSEQ_HICCUP_US 56000
`define CSSEQ_SS0_US 750
`define CSSEQ_SS1_US 1500
`define CSSEQ_SS2_US 3000
`define CSSEQ_SS3_US 6000
`define CSSEQ_DGL_NS 200

// ----------------------------------------
// reference and strap codes
// ----------------------------------------
`define CSSEQ_REF_FULL 10'h258
`define CSSEQ_SS_OPEN 5'h10
`define CSSEQ_SS_OPEN_IDX 2'h2
`define CSSEQ_MODE_OPEN 4'h8
`define CSSEQ_MODE_OPEN_FREQ 2'h1

// ----------------------------------------
// apb register byte offsets
// ----------------------------------------
`define CSSEQ_CTRL_OFS 8'h00
`define CSSEQ_STATUS_OFS 8'h04
`define CSSEQ_STRAP_OFS 8'h08
`define CSSEQ_REF_OFS 8'h0C
`define CSSEQ_CTRL_FORCED_CONTINUOUS_SEL_BIT 0

`endif

// ---- hdl/csseq_sync.v ----
// two flip-flop synchroniser for pin inputs
module csseq_sync
#(
   parameter W = 1
)
(
   // clock and reset
   input wire pclk,
   input wire presetn,
   // data
   input wire [W-1:0] d,
   output reg [W-1:0] q
);

reg [W-1:0] meta;

always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      meta <= {W{1'b0}};
      q <= {W{1'b0}};
   end
   else
   begin
      meta <= d;
      q <= meta;
   end
end

endmodule // csseq_sync

// ---- hdl/csseq_top.v ----
// start-up and shutdown sequencer with apb status and control
//
// Behaviour
// - initialization starts when reset (bias valid) releases, enable ignored
// - initialization lasts about 300 us
// - strap decodes captured once at end of init, held until reset
// - enable toggles never re-run or change strap decodes
// - after enable high, wait 0.5 ms power-on delay
// - then reference ramps from zero to 0.6 V over soft-start time
// - soft-start time is 0.75, 1.5, 3 or 6 ms
// - soft-start strap gives time, loop set and latch/hiccup; open is 3 ms
// - low-side switch held off until first high-side pulse on prebias
// - switching starts once reference exceeds sensed feedback
// - on regulation start 1 ms timer, then assert power good
// - enable low turns both drivers off at once
// - enable low discharges reference to zero
// - mode strap gives frequency and forced-continuous or skip; open 800 kHz
// - forced-continuous setting loaded at power-on, frozen at enable high
// - write while enabled is accepted; mode changes after enable toggle
// - enable pulses under 0.2 us are filtered out
// - hiccup response waits 56 ms then restarts, unlimited attempts
// - latch-off keeps drivers off until reset or enable toggle
`include "csseq_map.vh"
module csseq_top
#(
   parameter INIT_CYC = `CSSEQ_INIT_US * `CSSEQ_CLK_MHZ,
   parameter POD_CYC = `CSSEQ_POD_US * `CSSEQ_CLK_MHZ,
   parameter PG_CYC = `CSSEQ_PG_US * `CSSEQ_CLK_MHZ,
   parameter HICCUP_CYC = `CSSEQ_HICCUP_US * `CSSEQ_CLK_MHZ,
   parameter SS0_CYC = `CSSEQ_SS0_US * `CSSEQ_CLK_MHZ,
   parameter SS1_CYC = `CSSEQ_SS1_US * `CSSEQ_CLK_MHZ,
   parameter SS2_CYC = `CSSEQ_SS2_US * `CSSEQ_CLK_MHZ,
   parameter SS3_CYC = `CSSEQ_SS3_US * `CSSEQ_CLK_MHZ
)
(
   // clock and reset (reset is the bias-supply-valid indication)
   input wire pclk,
   input wire presetn,
   // apb slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output reg pslverr,
   // pins from outside
   input wire enable_pin,
   input wire [4:0] ss_strap_code,
   input wire [3:0] mode_strap_code,
   input wire fault_pin,
   input wire in_regulation,
   // converter core, same clock
   input wire [9:0] feedback_sense,
   input wire hs_pulse_seen,
   // outputs
   output reg [9:0] ref_level,
   output reg switching_en,
   output reg low_side_allow,
   output reg power_good_out,
   output reg [1:0] freq_sel,
   output reg skip_operation,
   output reg loop_set_b,
   output reg hiccup_sel
);

// ----------------------------------------
// states and derived counts
// ----------------------------------------
localparam ST_INIT = 4'h0;
localparam ST_WAIT_EN = 4'h1;
localparam ST_POD = 4'h2;
localparam ST_SOFT = 4'h3;
localparam ST_WAIT_REG = 4'h4;
localparam ST_PG_DLY = 4'h5;
localparam ST_RUN = 4'h6;
localparam ST_LATCHED = 4'h7;
localparam ST_HICCUP = 4'h8;
localparam DGL_CYC = `CSSEQ_DGL_NS / `CSSEQ_CLK_NS;

// ----------------------------------------
// strap decode helpers
// ----------------------------------------
function [1:0] ss_time_idx;
   input [4:0] code;
   begin
      if (code >= `CSSEQ_SS_OPEN)
         ss_time_idx = `CSSEQ_SS_OPEN_IDX;
      else
         ss_time_idx = code[1:0];
   end
endfunction

function [23:0] ss_cycles;
   input [1:0] idx;
   begin
      case (idx)
         2'h0: ss_cycles = SS0_CYC[23:0];
         2'h1: ss_cycles = SS1_CYC[23:0];
         2'h2: ss_cycles = SS2_CYC[23:0];
         default: ss_cycles = SS3_CYC[23:0];
      endcase
   end
endfunction

// ----------------------------------------
// input synchronisers and enable filter
// ----------------------------------------
wire en_sync;
wire en_filt;
wire fault_sync;
wire reg_sync;
wire [4:0] ss_sync;
wire [3:0] mode_sync;

csseq_sync #(.W(12)) u_sync
(
   .pclk(pclk),
   .presetn(presetn),
   .d({enable_pin, fault_pin, in_regulation, ss_strap_code, mode_strap_code}),
   .q({en_sync, fault_sync, reg_sync, ss_sync, mode_sync})
);

csseq_deglitch #(.LEN(DGL_CYC)) u_dgl
(
   .pclk(pclk),
   .presetn(presetn),
   .din(en_sync),
   .dout(en_filt)
);

// ----------------------------------------
// state, timer and latched settings
// ----------------------------------------
reg [3:0] state;
reg [3:0] next_state;
reg [23:0] cnt;
reg [23:0] step_cnt;
reg [1:0] ss_idx;
reg forced_continuous_sel_req;
reg strap_done;
reg en_seen_low;
reg [23:0] lim;
reg timer_done;
wire [23:0] step_len;
wire apb_wr;
wire apb_rd;
wire addr_ok;

assign step_len = ss_cycles(ss_idx) / {14'h0000, `CSSEQ_REF_FULL};

always @*
begin
   case (state)
      ST_INIT: lim = INIT_CYC[23:0];
      ST_POD: lim = POD_CYC[23:0];
      ST_PG_DLY: lim = PG_CYC[23:0];
      ST_HICCUP: lim = HICCUP_CYC[23:0];
      default: lim = 24'h00_0001;
   endcase
   timer_done = (cnt >= lim - 24'h00_0001);
end

always @*
begin
   next_state = state;
   case (state)
      ST_INIT:
      begin
         if (timer_done)
            next_state = ST_WAIT_EN;
      end
      ST_WAIT_EN:
      begin
         if (en_filt)
            next_state = ST_POD;
      end
      ST_POD:
      begin
         if (!en_filt)
            next_state = ST_WAIT_EN;
         else if (timer_done)
            next_state = ST_SOFT;
      end
      ST_SOFT:
      begin
         if (!en_filt)
            next_state = ST_WAIT_EN;
         else if (ref_level == `CSSEQ_REF_FULL)
            next_state = ST_WAIT_REG;
      end
      ST_WAIT_REG:
      begin
         if (!en_filt)
            next_state = ST_WAIT_EN;
         else if (fault_sync)
            next_state = hiccup_sel ? ST_HICCUP : ST_LATCHED;
         else if (reg_sync)
            next_state = ST_PG_DLY;
      end
      ST_PG_DLY, ST_RUN:
      begin
         if (!en_filt)
            next_state = ST_WAIT_EN;
         else if (fault_sync)
            next_state = hiccup_sel ? ST_HICCUP : ST_LATCHED;
         else if (state == ST_PG_DLY && timer_done)
            next_state = ST_RUN;
      end
      ST_LATCHED:
      begin
         if (!en_filt)
            next_state = ST_WAIT_EN;
      end
      ST_HICCUP:
      begin
         if (!en_filt)
            next_state = ST_WAIT_EN;
         else if (timer_done)
            next_state = ST_POD;
      end
      default: next_state = ST_INIT;
   endcase
end

// state and counters; reset release starts init regardless of enable
always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      state <= ST_INIT;
      cnt <= 24'h00_0000;
   end
   else
   begin
      state <= next_state;
      if (next_state != state)
         cnt <= 24'h00_0000;
      else if (!timer_done)
         cnt <= cnt + 24'h00_0001;
   end
end

// ----------------------------------------
// strap capture and mode latching
// ----------------------------------------
// captured once; only a reset clears strap_done, so enable cannot re-run it
always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      strap_done <= 1'b0;
      ss_idx <= `CSSEQ_SS_OPEN_IDX;
      loop_set_b <= 1'b0;
      hiccup_sel <= 1'b0;
      freq_sel <= `CSSEQ_MODE_OPEN_FREQ;
      forced_continuous_sel_req <= 1'b1;
   end
   else if (state == ST_INIT && timer_done && !strap_done)
   begin
      strap_done <= 1'b1;
      ss_idx <= ss_time_idx(ss_sync);
      loop_set_b <= (ss_sync < `CSSEQ_SS_OPEN) & ss_sync[2];
      hiccup_sel <= (ss_sync < `CSSEQ_SS_OPEN) & ss_sync[3];
      if (mode_sync >= `CSSEQ_MODE_OPEN)
      begin
         freq_sel <= `CSSEQ_MODE_OPEN_FREQ;
         forced_continuous_sel_req <= 1'b1;
      end
      else
      begin
         freq_sel <= mode_sync[1:0];
         forced_continuous_sel_req <= ~mode_sync[2];
      end
   end
   else if (apb_wr && paddr == `CSSEQ_CTRL_OFS)
   begin
      forced_continuous_sel_req <= pwdata[`CSSEQ_CTRL_FORCED_CONTINUOUS_SEL_BIT];
   end
end

// active mode loads the request only when enable goes high while waiting for enable
always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
      skip_operation <= 1'b0;
   else if (state == ST_WAIT_EN && en_filt)
      skip_operation <= ~forced_continuous_sel_req;
end

// ----------------------------------------
// reference ramp, drivers, power good
// ----------------------------------------
always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      ref_level <= 10'h000;
      step_cnt <= 24'h00_0000;
      switching_en <= 1'b0;
      low_side_allow <= 1'b0;
      power_good_out <= 1'b0;
   end
   else if (next_state == ST_SOFT || next_state == ST_WAIT_REG ||
            next_state == ST_PG_DLY || next_state == ST_RUN)
   begin
      if (state == ST_SOFT && ref_level != `CSSEQ_REF_FULL)
      begin
         if (step_cnt >= step_len - 24'h00_0001)
         begin
            step_cnt <= 24'h00_0000;
            ref_level <= ref_level + 10'h001;
         end
         else
         begin
            step_cnt <= step_cnt + 24'h00_0001;
         end
      end
      if (ref_level > feedback_sense)
         switching_en <= 1'b1;
      if (switching_en && hs_pulse_seen)
         low_side_allow <= 1'b1;
      power_good_out <= (next_state == ST_RUN);
   end
   else
   begin
      // any other state: drivers off, reference discharged, power good low
      ref_level <= 10'h000;
      step_cnt <= 24'h00_0000;
      switching_en <= 1'b0;
      low_side_allow <= 1'b0;
      power_good_out <= 1'b0;
   end
end

// ----------------------------------------
// apb slave: zero wait states
// ----------------------------------------
assign pready = 1'b1;
assign apb_wr = psel & penable & pwrite;
assign apb_rd = psel & ~penable & ~pwrite;
assign addr_ok = (paddr == `CSSEQ_CTRL_OFS) || (paddr == `CSSEQ_STATUS_OFS) ||
                 (paddr == `CSSEQ_STRAP_OFS) || (paddr == `CSSEQ_REF_OFS);

// read data is registered in the setup cycle, valid in the access cycle
always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
   end
   else if (psel & ~penable)
   begin
      pslverr <= ~addr_ok;
      prdata <= 32'h0000_0000;
      if (apb_rd)
      begin
         case (paddr)
            `CSSEQ_CTRL_OFS: prdata <= {31'h0000_0000, forced_continuous_sel_req};
            `CSSEQ_STATUS_OFS: prdata <= {24'h00_0000, power_good_out, skip_operation,
                                          switching_en, low_side_allow, state};
            `CSSEQ_STRAP_OFS: prdata <= {26'h000_0000, hiccup_sel, loop_set_b, ss_idx, freq_sel};
            `CSSEQ_REF_OFS: prdata <= {22'h00_0000, ref_level};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end
end

endmodule // csseq_top

// ---- tb/csseq_ctrl_model.sv ----
// system controller and converter core stand-in
module csseq_ctrl_model
(
   // clock and reset
   input wire pclk,
   input wire presetn,
   // bench command
   input wire en_cmd,
   // from the sequencer
   input wire [9:0] ref_level,
   input wire switching_en,
   // to the sequencer
   output logic enable_pin,
   output logic in_regulation,
   output logic [9:0] feedback_sense,
   output wire hs_pulse_seen
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] dly;
   // first high-side pulse lands a few cycles after switching starts
   assign hs_pulse_seen = dly[2];
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         enable_pin <= 1'b0;
         in_regulation <= 1'b0;
         dly <= 3'h0;
         feedback_sense <= 10'h0100;
      end
      else
      begin
         enable_pin <= en_cmd;
         // prebiased output below full scale until switching, then it tracks the reference
         feedback_sense <= switching_en ? ref_level : 10'h0100;
         in_regulation <= (ref_level == 10'h0258) && switching_en;
         dly <= {dly[1:0], switching_en};
      end
   end
endmodule // csseq_ctrl_model

// ---- tb/csseq_properties.sv ----
// concurrent checks on the start-up sequencer ports
module csseq_properties
#(
   parameter INIT_CYC = 20,
   parameter PG_CYC = 40
)
(
   // clock and reset
   input wire pclk,
   input wire presetn,
   // pins
   input wire enable_pin,
   input wire in_regulation,
   input wire [9:0] feedback_sense,
   input wire hs_pulse_seen,
   // outputs
   input wire [9:0] ref_level,
   input wire switching_en,
   input wire low_side_allow,
   input wire power_good_out,
   input wire [1:0] freq_sel,
   input wire loop_set_b,
   input wire hiccup_sel
);
   timeunit 1ns;
   timeprecision 1ns;
   int unsigned up_cnt;
   int unsigned reg_cnt;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // up_cnt saturates so it never wraps on long runs
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         up_cnt <= 0;
         reg_cnt <= 0;
      end
      else
      begin
         up_cnt <= (up_cnt < INIT_CYC + 4) ? up_cnt + 1 : up_cnt;
         reg_cnt <= in_regulation ? reg_cnt + 1 : 0;
      end
   end
   // -----
   // shutdown seen after the enable filter
   // -----
   sequence en_gone;
      $fell(enable_pin) ##1 !enable_pin [*8] ##1 !enable_pin [*8];
   endsequence
   chk_shut_down: assert property (en_gone |-> ##[0:4]
      (ref_level == 0 && !switching_en && !low_side_allow && !power_good_out))
      else $error("outputs not cleared after enable low");
   chk_init_quiet: assert property (up_cnt < INIT_CYC |-> !switching_en && !power_good_out && ref_level == 0)
      else $error("activity during initialization");
   chk_strap_hold: assert property (up_cnt == INIT_CYC + 4 |-> $stable({freq_sel, loop_set_b, hiccup_sel}))
      else $error("strap decode changed");
   chk_ref_ceiling: assert property (ref_level <= 10'h0258)
      else $error("reference above full scale");
   chk_ref_step: assert property (ref_level > $past(ref_level) |-> ref_level == $past(ref_level) + 10'h0001)
      else $error("reference jumped");
   chk_sw_above_fb: assert property ($rose(switching_en) |-> ref_level > feedback_sense)
      else $error("switching before reference crossed feedback");
   chk_ls_needs_hs: assert property ($rose(low_side_allow) |-> $past(switching_en) && $past(hs_pulse_seen))
      else $error("low side allowed without switching");
   chk_pg_full_ref: assert property (power_good_out |-> ref_level == 10'h0258)
      else $error("power good before ramp end");
   chk_pg_delay: assert property ($rose(power_good_out) |-> reg_cnt >= PG_CYC)
      else $error("power good delay too short");
endmodule // csseq_properties

bind csseq_top csseq_properties #(.INIT_CYC(INIT_CYC), .PG_CYC(PG_CYC)) csseq_properties_inst
(
   .pclk(pclk),
   .presetn(presetn),
   .enable_pin(enable_pin),
   .in_regulation(in_regulation),
   .feedback_sense(feedback_sense),
   .hs_pulse_seen(hs_pulse_seen),
   .ref_level(ref_level),
   .switching_en(switching_en),
   .low_side_allow(low_side_allow),
   .power_good_out(power_good_out),
   .freq_sel(freq_sel),
   .loop_set_b(loop_set_b),
   .hiccup_sel(hiccup_sel)
);

// ---- tb/csseq_top_tb.sv ----
// self-checking bench for the start-up sequencer
module csseq_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk, presetn, psel, penable, pwrite, fault_pin, en_cmd;
   logic [7:0] paddr;
   logic [31:0] pwdata, rd;
   logic [4:0] ss_strap_code;
   logic [3:0] mode_strap_code;
   wire [31:0] prdata;
   wire [9:0] ref_level, feedback_sense;
   wire [1:0] freq_sel;
   wire pready, pslverr, enable_pin, in_regulation, hs_pulse_seen;
   wire switching_en, low_side_allow, power_good_out, skip_operation, loop_set_b, hiccup_sel;
   int n_fail = 0;
   int total_checks = 0;
   int k, m;
   // short counts keep the run small
   csseq_top #(.INIT_CYC(20), .POD_CYC(30), .PG_CYC(40), .HICCUP_CYC(50), .SS0_CYC(600),
      .SS1_CYC(1200), .SS2_CYC(1800), .SS3_CYC(2400)) csseq_top_inst (.*);
   csseq_ctrl_model csseq_ctrl_model_inst (.*);
   initial
   begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   // -----
   // tasks
   // -----
   task finish_test;
      $display("checks %0d errors %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      // one idle edge so a following call never re-drives psel in the same step
      @(posedge pclk);
   endtask
   task rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(rd, exp);
   endtask
   task rst(input int s, input int md);
      presetn <= 1'b0;
      ss_strap_code <= s[4:0];
      mode_strap_code <= md[3:0];
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      repeat (30) @(posedge pclk);
   endtask
   task wait_pg;
      k = 0;
      while (power_good_out !== 1'b1 && k < 9000)
      begin
         @(posedge pclk);
         k++;
      end
      chk(power_good_out, 1);
   endtask
   task fault;
      fault_pin <= 1'b1;
      repeat (4) @(posedge pclk);
      fault_pin <= 1'b0;
      repeat (8) @(posedge pclk);
   endtask
   // -----
   // tests
   // -----
   initial
   begin
      {presetn, psel, penable, pwrite, fault_pin, en_cmd} <= 6'h00;
      paddr <= 8'h00;
      pwdata <= 32'h0000_0000;
      @(posedge pclk);
      for (int i = 0; i < 17; i++)
      begin
         m = i % 9;
         rst(i, m);
         rdchk(8'h08, ((i < 16) ? (i & 15) << 2 : 8) | ((m < 8) ? (m & 3) : 1));
         rdchk(8'h00, (m < 8) ? !m[2] : 1);
      end
      rdchk(8'h20, 0);
      chk(pslverr, 1);
      // straps moved after init and a short enable glitch change nothing
      ss_strap_code <= 5'h00;
      mode_strap_code <= 4'h0;
      en_cmd <= 1'b1;
      repeat (4) @(posedge pclk);
      en_cmd <= 1'b0;
      repeat (30) @(posedge pclk);
      rdchk(8'h04, 1);
      en_cmd <= 1'b1;
      k = 0;
      while (ref_level === 10'h0000 && k < 500)
      begin
         @(posedge pclk);
         k++;
      end
      chk(k >= 42 && k < 60, 1);
      wait_pg;
      rdchk(8'h08, 11);
      chk(skip_operation, 1);
      apb(1'b1, 8'h00, 32'h0000_0001);
      rdchk(8'h00, 1);
      chk(skip_operation, 1);
      // shutdown from regulation
      en_cmd <= 1'b0;
      repeat (20) @(posedge pclk);
      rdchk(8'h0C, 0);
      chk({switching_en, low_side_allow, power_good_out}, 0);
      en_cmd <= 1'b1;
      wait_pg;
      chk(skip_operation, 0);
      fault;
      rdchk(8'h04, 7);
      chk(switching_en, 0);
      en_cmd <= 1'b0;
      repeat (20) @(posedge pclk);
      en_cmd <= 1'b1;
      wait_pg;
      // enable already high while initialization runs
      rst(8, 0);
      wait_pg;
      fault;
      rdchk(8'h04, 8);
      wait_pg;
      finish_test;
   end
   initial
   begin
      // the whole sequence needs well under 20000 cycles
      #(20000 * 20);
      n_fail++;
      finish_test;
   end
endmodule // csseq_top_tb
